// ===== hw/pmcl_top.sv
`timescale 1ns/10ps
module pmcl_top
  import pmcl_pkg::*;
(
  input wire logic mclk, // system clock
  input wire logic rst_n, // sync reset, power-up
  input wire logic ce, // clock enable, mclk side
  input wire logic link_clk, // link oversampling clock
  input wire logic scl_pin, // bus clock pin
  input wire logic sda_pin, // bus data pin
  output logic sda_out, // data pin level when driven
  output logic sda_oe, // data pin drive enable
  input wire logic en_pin, // enable pin level
  input wire logic bias_comm_ok, // bias above 3.7 V
  input wire logic bias_uvlo_ok, // bias start/stop comparator
  input wire logic en_start_ok, // enable start comparator
  input wire logic [3:0] strap_code, // decoded strap resistor
  input wire logic ss_above_fb, // soft-start ramp above feedback
  input wire logic vout_below_floor, // output below floor plus ramp
  input pmcl_tlm_t tlm, // telemetry, mclk domain
  output logic hs_drive, // high-side switch on
  output logic ls_drive, // low-side switch on
  output logic [15:0] vout_setpoint, // target, 0.625 mV steps
  output logic [15:0] analog_pd_ctl, // analog power-down control
  output logic conv_running, // conversion enabled
  output logic cfg_crc_fail // configuration check failed
);
  pmcl_pins_t pin_a, pin_s;
  logic [1:0] lrst_sy;
  pmcl_ld_t ld_q;
  logic [3:0] file_q;
  logic [2:0] widx_q;
  logic [15:0] crc_q;
  logic [6:0] ld_idx;
  logic [15:0] store_q [DEPTH];
  logic [6:0] ptr_q;
  logic [4:0] prog_cnt_q;
  logic [6:0] base_q, target_q;
  logic [2:0] mode_q;
  logic [15:0] vout_q, apd_q, pw_q, rdata_q, rd_val, tlm_val;
  pmcl_prot_t prot_q, prot_w;
  pmcl_status_t stat;
  logic locked_q, acc_fault_q, ready_q, ack_tog_q, req_prev_q;
  logic req_ev, is_tlm, is_open, rd_ok, wr_ok, wr_ev;
  logic armed_q, run_q, prebias_q, floor_prev_q;
  logic [ON_W-1:0] on_cnt_q;
  logic [26:0] sp_prod, sp_shift;
  logic link_req_tog, link_sda_oe;
  pmcl_req_t lreq;

  // level inputs from pins: two stages before use
  always_ff @(posedge mclk) begin
    if (ce) begin
      pin_a <= '{en: en_pin, bias_comm: bias_comm_ok, bias_uvlo: bias_uvlo_ok,
                 en_start: en_start_ok, ss_fb: ss_above_fb, floor_low: vout_below_floor,
                 req_tog: link_req_tog, strap: strap_code};
      pin_s <= pin_a;
    end
  end

  always_ff @(posedge link_clk) begin
    lrst_sy <= {lrst_sy[0], rst_n};
  end

  pmcl_link u_link (
    .link_clk(link_clk),
    .link_rst_n(lrst_sy[1]),
    .scl_pin(scl_pin),
    .sda_pin(sda_pin),
    .ready(ready_q),
    .addr(target_q),
    .ack_tog(ack_tog_q),
    .rdata(rdata_q),
    .sda_oe(link_sda_oe),
    .req_tog(link_req_tog),
    .req(lreq)
  );

  assign sda_oe = link_sda_oe;
  always_ff @(posedge mclk) begin
    sda_out <= 1'b0;
  end

  assign ld_idx = 7'(int'(file_q) * WPF + int'(widx_q));

  // power-up loader
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ld_q <= LD_WAIT;
      file_q <= 4'h0;
      widx_q <= 3'h0;
      crc_q <= CRC_INIT;
    end else if (ce) begin
      unique case (ld_q)
        LD_WAIT: if (pin_s.bias_comm) begin
          file_q <= pin_s.strap;
          widx_q <= 3'h0;
          crc_q <= CRC_INIT;
          ld_q <= LD_READ;
        end
        LD_READ: begin
          if (widx_q != 3'(W_CRC)) begin
            crc_q <= crc16_word(crc_q, store_q[ld_idx]);
            widx_q <= widx_q + 3'h1;
          end else if (store_q[ld_idx] == crc_q) begin
            ld_q <= LD_DONE;
          end else begin
            ld_q <= LD_FAIL;
          end
        end
        LD_DONE, LD_FAIL: ld_q <= ld_q;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ready_q <= 1'b0;
      target_q <= 7'h00;
    end else if (ce) begin
      ready_q <= pin_s.bias_comm && (ld_q == LD_DONE || ld_q == LD_FAIL);
      target_q <= base_q + {3'h0, file_q};
    end
  end

  assign req_ev = pin_s.req_tog ^ req_prev_q;
  assign wr_ev = req_ev && lreq.wr && wr_ok;

  always_comb begin
    is_tlm = 1'b1;
    unique case (lreq.cmd)
      CMD_READ_VIN: tlm_val = tlm.vin;
      CMD_READ_IIN: tlm_val = tlm.iin;
      CMD_READ_VOUT: tlm_val = tlm.vout;
      CMD_READ_IOUT: tlm_val = tlm.iout;
      CMD_READ_TEMP: tlm_val = tlm.temp;
      CMD_READ_POUT: tlm_val = tlm.pout;
      CMD_READ_PIN: tlm_val = tlm.pin;
      default: begin
        is_tlm = 1'b0;
        tlm_val = REFUSED_WORD;
      end
    endcase
  end

  assign stat = '{rsv: 3'h0, prog_cnt: prog_cnt_q, rsv2: 3'h0, acc_fault: acc_fault_q,
                  ld_done: ld_q == LD_DONE, running: run_q, locked: locked_q,
                  crc_fail: ld_q == LD_FAIL};

  always_comb begin
    unique case (lreq.cmd)
      CMD_VOUT_MODE: rd_val = {13'h0000, mode_q};
      CMD_VOUT_CMD: rd_val = vout_q;
      CMD_BASE_ADDR: rd_val = {9'h000, base_q};
      CMD_ANALOG_PD: rd_val = apd_q;
      CMD_PROT: rd_val = prot_q;
      CMD_STATUS: rd_val = stat;
      CMD_STORE_ADDR: rd_val = {9'h000, ptr_q};
      CMD_STORE_DATA: rd_val = (32'(ptr_q) < DEPTH) ? store_q[ptr_q] : REFUSED_WORD;
      default: rd_val = tlm_val;
    endcase
  end

  assign is_open = (lreq.cmd == CMD_STATUS) || (lreq.cmd == CMD_PROT);
  // telemetry-only: reads of telemetry, no writes
  assign rd_ok = prot_q.tlm_only ? is_tlm :
                 locked_q ? (is_tlm || is_open) :
                 (is_tlm || is_open || !prot_q.rp);
  assign wr_ok = prot_q.tlm_only ? 1'b0 :
                 locked_q ? (lreq.cmd == CMD_PASSWORD) :
                 (!prot_q.wp || is_open || lreq.cmd == CMD_PASSWORD);

  // answer every request, refused reads return all ones
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      req_prev_q <= 1'b0;
      ack_tog_q <= 1'b0;
      rdata_q <= REFUSED_WORD;
      acc_fault_q <= 1'b0;
    end else if (ce) begin
      req_prev_q <= pin_s.req_tog;
      if (req_ev) begin
        ack_tog_q <= ~ack_tog_q;
        if (!lreq.wr) begin
          rdata_q <= rd_ok ? rd_val : REFUSED_WORD;
        end
      end
      // set wins over a clear in the same cycle
      if (req_ev && !(lreq.wr ? wr_ok : rd_ok)) begin
        acc_fault_q <= 1'b1;
      end else if (wr_ev && lreq.cmd == CMD_STATUS && lreq.data[4]) begin
        acc_fault_q <= 1'b0;
      end
    end
  end

  assign prot_w = lreq.data;

  // protection and password
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      prot_q <= '0;
      locked_q <= 1'b0;
      pw_q <= PW_DEFAULT;
    end else if (ce && wr_ev) begin
      if (lreq.cmd == CMD_PROT) begin
        prot_q <= '{rsv: 12'h000, lock: 1'b0, tlm_only: prot_w.tlm_only,
                    rp: prot_w.rp, wp: prot_w.wp};
        locked_q <= locked_q | prot_w.lock;
      end
      if (lreq.cmd == CMD_PASSWORD) begin
        if (!locked_q) begin
          pw_q <= lreq.data;
        end else if (lreq.data == pw_q) begin
          locked_q <= 1'b0;
        end
      end
    end
  end

  // working registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      base_q <= DEF_BASE[6:0];
      mode_q <= DEF_MODE[2:0];
      vout_q <= DEF_VOUT;
      apd_q <= DEF_APD;
    end else if (ce) begin
      // copy stored file while it is checked
      if (ld_q == LD_READ) begin
        unique case (int'(widx_q))
          W_BASE: base_q <= store_q[ld_idx][6:0];
          W_MODE: mode_q <= (store_q[ld_idx][2:0] > MODE_MAX) ? MODE_MAX
                                                               : store_q[ld_idx][2:0];
          W_VOUT: vout_q <= store_q[ld_idx];
          W_APD: apd_q <= store_q[ld_idx];
          default: ;
        endcase
      end else if (wr_ev) begin
        unique case (lreq.cmd)
          CMD_BASE_ADDR: base_q <= lreq.data[6:0];
          CMD_VOUT_MODE: if (lreq.data[2:0] <= MODE_MAX && lreq.data[15:3] == 13'h0000) begin
            mode_q <= lreq.data[2:0];
          end
          CMD_VOUT_CMD: vout_q <= lreq.data;
          CMD_ANALOG_PD: apd_q <= lreq.data;
          default: ;
        endcase
      end
    end
  end

  // non-volatile store model; counter would live in the store itself
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        store_q[i] <= DEF_FILE[i % WPF];
      end
      ptr_q <= 7'h00;
      prog_cnt_q <= 5'h00;
    end else if (ce && wr_ev) begin
      if (lreq.cmd == CMD_STORE_ADDR) begin
        ptr_q <= lreq.data[6:0];
      end
      if (lreq.cmd == CMD_STORE_DATA && prog_cnt_q < PROG_LIMIT && 32'(ptr_q) < DEPTH) begin
        store_q[ptr_q] <= lreq.data;
        prog_cnt_q <= prog_cnt_q + 5'h01;
      end
    end
  end

  // scale to 0.625 mV steps, truncating
  assign sp_prod = 27'(vout_q) * VOUT_SCALE;
  assign sp_shift = sp_prod >> (MODE_TOP - {1'b0, mode_q});

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      vout_setpoint <= 16'h0000;
      analog_pd_ctl <= DEF_APD;
      cfg_crc_fail <= 1'b0;
    end else if (ce) begin
      vout_setpoint <= (sp_shift[26:16] != 11'h000) ? 16'hffff : sp_shift[15:0];
      // host value passed on as written
      analog_pd_ctl <= apd_q;
      cfg_crc_fail <= ld_q == LD_FAIL;
    end
  end

  // start gating
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      armed_q <= 1'b1;
      run_q <= 1'b0;
      prebias_q <= 1'b0;
    end else if (ce) begin
      // bias dropout needs an enable toggle
      if (!pin_s.bias_uvlo) begin
        armed_q <= 1'b0;
      end else if (!pin_s.en) begin
        armed_q <= 1'b1;
      end
      run_q <= (ld_q == LD_DONE) && armed_q && pin_s.en && pin_s.bias_uvlo
               && pin_s.en_start;
      if (!run_q) begin
        prebias_q <= 1'b1;
      end else if (pin_s.ss_fb) begin
        prebias_q <= 1'b0;
      end
    end
  end

  // switch drive
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      floor_prev_q <= 1'b0;
      on_cnt_q <= '0;
      hs_drive <= 1'b0;
      ls_drive <= 1'b0;
      conv_running <= 1'b0;
    end else if (ce) begin
      floor_prev_q <= pin_s.floor_low;
      conv_running <= run_q;
      if (!run_q || prebias_q) begin
        on_cnt_q <= '0;
      end else if (on_cnt_q != '0) begin
        on_cnt_q <= on_cnt_q - 1'b1;
      end else if (pin_s.floor_low && !floor_prev_q) begin
        on_cnt_q <= ON_LOAD;
      end
      hs_drive <= run_q && !prebias_q && (on_cnt_q != '0 ||
                  (pin_s.floor_low && !floor_prev_q));
      ls_drive <= run_q && !prebias_q && on_cnt_q == '0 &&
                  !(pin_s.floor_low && !floor_prev_q);
    end
  end
endmodule // pmcl_top

// ===== hw/pmcl_pkg.sv
package pmcl_pkg;
  localparam int MCLK_HZ = 20_000_000;
  localparam int ON_TIME_NS = 250;
  // fixed on-time rounded up to whole mclk cycles
  localparam int ON_CYC = int'((longint'(ON_TIME_NS) * MCLK_HZ + 64'd999_999_999)
                               / 64'd1_000_000_000);
  localparam int ON_W = 4;
  localparam logic [ON_W-1:0] ON_LOAD = ON_W'(ON_CYC);

  localparam logic [7:0] CMD_VOUT_MODE = 8'h20;
  localparam logic [7:0] CMD_VOUT_CMD = 8'h21;
  localparam logic [7:0] CMD_BASE_ADDR = 8'h40;
  localparam logic [7:0] CMD_ANALOG_PD = 8'h6c;
  localparam logic [7:0] CMD_READ_VIN = 8'h88;
  localparam logic [7:0] CMD_READ_IIN = 8'h89;
  localparam logic [7:0] CMD_READ_VOUT = 8'h8b;
  localparam logic [7:0] CMD_READ_IOUT = 8'h8c;
  localparam logic [7:0] CMD_READ_TEMP = 8'h8d;
  localparam logic [7:0] CMD_READ_POUT = 8'h96;
  localparam logic [7:0] CMD_READ_PIN = 8'h97;
  localparam logic [7:0] CMD_PROT = 8'hd0;
  localparam logic [7:0] CMD_PASSWORD = 8'hd1;
  localparam logic [7:0] CMD_STATUS = 8'hd2;
  localparam logic [7:0] CMD_STORE_ADDR = 8'hd3;
  localparam logic [7:0] CMD_STORE_DATA = 8'hd4;

  localparam int FILES = 16;
  localparam int WPF = 5;
  localparam int DEPTH = FILES * WPF;
  localparam int W_BASE = 0;
  localparam int W_MODE = 1;
  localparam int W_VOUT = 2;
  localparam int W_APD = 3;
  localparam int W_CRC = 4;
  localparam logic [4:0] PROG_LIMIT = 5'h18;

  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'h0000;
  localparam logic [15:0] DEF_BASE = 16'h0040;
  localparam logic [15:0] DEF_MODE = 16'h0002;
  localparam logic [15:0] DEF_VOUT = 16'h0000;
  localparam logic [15:0] DEF_APD = 16'h0000;
  localparam logic [15:0] PW_DEFAULT = 16'h0000;
  localparam logic [15:0] REFUSED_WORD = 16'hffff;
  localparam logic [2:0] MODE_MAX = 3'h4;
  localparam logic [3:0] MODE_TOP = 4'hc;
  // 1 V expressed in 0.625 mV steps
  localparam logic [26:0] VOUT_SCALE = 27'h640;
  localparam logic [7:0] TX_IDLE = 8'hff;

  function automatic logic [15:0] crc16_word(input logic [15:0] c, input logic [15:0] w);
    logic [15:0] r;
    r = c;
    for (int i = 15; i >= 0; i--) begin
      r = (r[15] ^ w[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  localparam logic [15:0] DEF_CRC = crc16_word(crc16_word(crc16_word(crc16_word(
    CRC_INIT, DEF_BASE), DEF_MODE), DEF_VOUT), DEF_APD);
  localparam logic [15:0] DEF_FILE [WPF] = '{DEF_BASE, DEF_MODE, DEF_VOUT, DEF_APD, DEF_CRC};

  typedef enum {LD_WAIT, LD_READ, LD_DONE, LD_FAIL} pmcl_ld_t;
  typedef enum {L_IDLE, L_ADDR, L_CMD, L_WLO, L_WHI, L_RLO, L_RHI} pmcl_lst_t;

  typedef struct packed {
    logic wr;
    logic [7:0] cmd;
    logic [15:0] data;
  } pmcl_req_t;

  typedef struct packed {
    logic [15:0] vin, vout, iin, iout, pin, pout, temp;
  } pmcl_tlm_t;

  typedef struct packed {
    logic [11:0] rsv;
    logic lock, tlm_only, rp, wp;
  } pmcl_prot_t;

  typedef struct packed {
    logic [2:0] rsv;
    logic [4:0] prog_cnt;
    logic [2:0] rsv2;
    logic acc_fault, ld_done, running, locked, crc_fail;
  } pmcl_status_t;

  typedef struct packed {
    logic en, bias_comm, bias_uvlo, en_start, ss_fb, floor_low, req_tog;
    logic [3:0] strap;
  } pmcl_pins_t;
endpackage

// ===== hw/pmcl_link.sv
`timescale 1ns/10ps
module pmcl_link
  import pmcl_pkg::*;
(
  input wire logic link_clk, // oversampling clock
  input wire logic link_rst_n, // reset, link domain
  input wire logic scl_pin, // bus clock pin
  input wire logic sda_pin, // bus data pin
  input wire logic ready, // mclk level: may answer
  input wire logic [6:0] addr, // target address, quasi-static
  input wire logic ack_tog, // mclk answer toggle
  input wire logic [15:0] rdata, // read word, stable after ack
  output logic sda_oe, // pull data low
  output logic req_tog, // request toggle
  output pmcl_req_t req // request held until next
);
  logic [2:0] scl_sy, sda_sy;
  logic [1:0] rdy_sy, ack_sy;
  logic scl_rise, scl_fall, start, stop, resp_ok;
  pmcl_lst_t st_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q, tx_q, lo_q, hi_q;
  logic [6:0] own_q;

  always_ff @(posedge link_clk) begin
    scl_sy <= {scl_sy[1:0], scl_pin};
    sda_sy <= {sda_sy[1:0], sda_pin};
    rdy_sy <= {rdy_sy[0], ready};
    ack_sy <= {ack_sy[0], ack_tog};
  end

  assign scl_rise = scl_sy[1] & ~scl_sy[2];
  assign scl_fall = ~scl_sy[1] & scl_sy[2];
  assign start = scl_sy[1] & scl_sy[2] & sda_sy[2] & ~sda_sy[1];
  assign stop = scl_sy[1] & scl_sy[2] & ~sda_sy[2] & sda_sy[1];
  assign resp_ok = (ack_sy[1] == req_tog);

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      st_q <= L_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      tx_q <= TX_IDLE;
      lo_q <= 8'h00;
      hi_q <= 8'h00;
      own_q <= 7'h00;
      sda_oe <= 1'b0;
      req_tog <= 1'b0;
      req <= '0;
    end else if (stop || !rdy_sy[1]) begin
      st_q <= L_IDLE;
      sda_oe <= 1'b0;
    end else if (start) begin
      st_q <= L_ADDR;
      cnt_q <= 4'h0;
      sda_oe <= 1'b0;
      own_q <= addr;
    end else if (scl_rise) begin
      if (cnt_q != 4'h8) begin
        sh_q <= {sh_q[6:0], sda_sy[1]};
        cnt_q <= cnt_q + 4'h1;
      end else begin
        cnt_q <= 4'h0;
        // host ack decides whether the next byte goes out; skip our own address ack
        if (!sda_oe && st_q == L_RLO && !sda_sy[1]) begin
          st_q <= L_RHI;
          tx_q <= hi_q;
        end else if (st_q == L_RHI && !sda_sy[1]) begin
          tx_q <= TX_IDLE;
        end else if (!sda_oe && (st_q == L_RLO || st_q == L_RHI)) begin
          st_q <= L_IDLE;
        end
      end
    end else if (scl_fall) begin
      if (cnt_q == 4'h8) begin
        unique case (st_q)
          L_ADDR: begin
            if (sh_q[7:1] == own_q) begin
              sda_oe <= 1'b1;
              st_q <= sh_q[0] ? L_RLO : L_CMD;
              tx_q <= resp_ok ? rdata[7:0] : TX_IDLE;
              hi_q <= resp_ok ? rdata[15:8] : TX_IDLE;
            end else begin
              st_q <= L_IDLE;
            end
          end
          L_CMD: begin
            sda_oe <= 1'b1;
            req <= '{wr: 1'b0, cmd: sh_q, data: 16'h0000};
            req_tog <= ~req_tog;
            st_q <= L_WLO;
          end
          L_WLO: begin
            sda_oe <= 1'b1;
            lo_q <= sh_q;
            st_q <= L_WHI;
          end
          L_WHI: begin
            sda_oe <= 1'b1;
            req <= '{wr: 1'b1, cmd: req.cmd, data: {sh_q, lo_q}};
            req_tog <= ~req_tog;
            st_q <= L_IDLE;
          end
          L_RLO, L_RHI: sda_oe <= 1'b0;
          L_IDLE: sda_oe <= 1'b0;
        endcase
      end else if (st_q == L_RLO || st_q == L_RHI) begin
        sda_oe <= ~tx_q[3'(4'h7 - cnt_q)];
      end else begin
        sda_oe <= 1'b0;
      end
    end
  end
endmodule // pmcl_link

// ===== tb/pmcl_host.sv
`timescale 1ns/10ps
module pmcl_host (
  input wire logic mclk, // pacing clock
  input wire logic dev_oe, // device pulls data low
  output logic scl_pin, // bus clock, host driven
  output logic sda_pin // data wire with pull-up
);
  logic host_oe = 1'b0;
  assign sda_pin = ~(host_oe | dev_oe);
  initial scl_pin = 1'b1;
  task automatic q();
    repeat (8) @(negedge mclk);
  endtask
  // doubles as repeated start
  task automatic start();
    q();
    host_oe = 1'b0;
    q();
    scl_pin = 1'b1;
    q();
    host_oe = 1'b1;
    q();
    scl_pin = 1'b0;
  endtask
  task automatic stop();
    q();
    host_oe = 1'b1;
    q();
    scl_pin = 1'b1;
    q();
    host_oe = 1'b0;
  endtask
  task automatic bit_x(input logic b, output logic r);
    q();
    host_oe = ~b;
    q();
    scl_pin = 1'b1;
    q();
    r = sda_pin;
    q();
    scl_pin = 1'b0;
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(b[i], r);
    end
    bit_x(1'b1, r);
    ack = ~r;
  endtask
  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, d[i]);
    end
    bit_x(nack, r);
  endtask
endmodule // pmcl_host

// ===== tb/pmcl_top_properties.sv
`timescale 1ns/10ps
module pmcl_top_properties (
  input wire logic mclk, // system clock
  input wire logic rst_n, // sync reset
  input wire logic scl_pin, // bus clock pin
  input wire logic sda_oe, // data drive enable
  input wire logic en_pin, // enable pin
  input wire logic bias_uvlo_ok, // bias comparator
  input wire logic en_start_ok, // enable comparator
  input wire logic ss_above_fb, // ramp above feedback
  input wire logic hs_drive, // high side
  input wire logic ls_drive, // low side
  input wire logic conv_running, // running
  input wire logic cfg_crc_fail, // check failed
  input wire logic [15:0] vout_setpoint, // setpoint
  input wire logic [15:0] analog_pd_ctl // analog control
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  AST_HS_WIDTH: assert property ($rose(hs_drive) |-> hs_drive [*6] ##1 !hs_drive)
    else $error("high-side pulse width wrong");
  AST_NO_OVERLAP: assert property (!(hs_drive && ls_drive))
    else $error("both switches on");
  AST_PREBIAS:
    assert property ($rose(conv_running) && !ss_above_fb && !$past(ss_above_fb, 3)
      |-> (!hs_drive && !ls_drive) [*2])
    else $error("switch on before ramp passed feedback");
  AST_HS_RUN: assert property ($rose(hs_drive) |-> conv_running)
    else $error("pulse while not running");
  AST_RUN_CAUSE:
    assert property ($rose(conv_running) |-> $past(en_pin, 2) && $past(bias_uvlo_ok, 2)
      && $past(en_start_ok, 2))
    else $error("run without enable and thresholds");
  AST_UVLO_STOP: assert property ($fell(bias_uvlo_ok) |-> ##[1:6] !conv_running)
    else $error("run kept after bias drop");
  AST_CRC_BLOCK: assert property (cfg_crc_fail |-> !conv_running && !hs_drive)
    else $error("run despite check failure");
  AST_ACK_LOW: assert property ($changed(sda_oe) |-> !scl_pin)
    else $error("data moved while clock high");
  AST_RESET_OUT:
    assert property ($rose(rst_n) |-> !conv_running && !hs_drive && !ls_drive
      && vout_setpoint == 16'h0000 && analog_pd_ctl == 16'h0000)
    else $error("outputs not clear after reset");
  cover property ($rose(hs_drive));
  cover property ($rose(sda_oe));
  cover property ($fell(conv_running));
endmodule // pmcl_top_properties

bind pmcl_top pmcl_top_properties i_pmcl_top_properties (
  .mclk(mclk), .rst_n(rst_n), .scl_pin(scl_pin), .sda_oe(sda_oe), .en_pin(en_pin),
  .bias_uvlo_ok(bias_uvlo_ok), .en_start_ok(en_start_ok), .ss_above_fb(ss_above_fb),
  .hs_drive(hs_drive), .ls_drive(ls_drive), .conv_running(conv_running),
  .cfg_crc_fail(cfg_crc_fail), .vout_setpoint(vout_setpoint), .analog_pd_ctl(analog_pd_ctl)
);

// ===== tb/pmcl_top_tb.sv
`timescale 1ns/10ps
`define CHK(g, e) \
  begin \
    checks_done++; \
    if ((g) !== (e)) begin \
      n_errors++; \
      $display("[FAIL] %0t got %h exp %h", $time, g, e); \
    end \
  end
module pmcl_top_tb
  import pmcl_pkg::*;
;
  // strap offset 3 on base bus_base_address
  localparam logic [6:0] DEV = 7'h43;
  logic mclk = 1'b0, link_clk = 1'b0, rst_n = 1'b0, en_pin = 1'b0, bias_comm_ok = 1'b0;
  logic ce = 1'b1;
  logic bias_uvlo_ok = 1'b0, en_start_ok = 1'b0, ss_above_fb = 1'b0, vout_below_floor = 1'b0;
  logic scl_pin, sda_pin, sda_out, sda_oe, hs_drive, ls_drive, conv_running, cfg_crc_fail;
  logic [15:0] vout_setpoint, analog_pd_ctl;
  pmcl_tlm_t tlm = {16'h0a01, 16'h0a02, 16'h0a03, 16'h0a04, 16'h0a05, 16'h0a06, 16'h0a07};
  int n_errors = 0, checks_done = 0, cyc = 0;
  always #25 mclk = ~mclk;
  always #40 link_clk = ~link_clk;
  pmcl_top i_pmcl_top (
    .mclk(mclk), .rst_n(rst_n), .ce(ce), .link_clk(link_clk), .scl_pin(scl_pin),
    .sda_pin(sda_pin), .sda_out(sda_out), .sda_oe(sda_oe), .en_pin(en_pin),
    .bias_comm_ok(bias_comm_ok), .bias_uvlo_ok(bias_uvlo_ok), .en_start_ok(en_start_ok),
    .strap_code(4'h3), .ss_above_fb(ss_above_fb), .vout_below_floor(vout_below_floor),
    .tlm(tlm), .hs_drive(hs_drive), .ls_drive(ls_drive), .vout_setpoint(vout_setpoint),
    .analog_pd_ctl(analog_pd_ctl), .conv_running(conv_running), .cfg_crc_fail(cfg_crc_fail)
  );
  pmcl_host i_pmcl_host (.mclk(mclk), .dev_oe(sda_oe), .scl_pin(scl_pin), .sda_pin(sda_pin));
  task automatic wrap_up();
    if (n_errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_errors++;
      wrap_up();
    end
  end
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [15:0] d,
                    output logic ok);
    logic [3:0] k;
    i_pmcl_host.start();
    i_pmcl_host.wbyte({a, 1'b0}, k[0]);
    i_pmcl_host.wbyte(c, k[1]);
    i_pmcl_host.wbyte(d[7:0], k[2]);
    i_pmcl_host.wbyte(d[15:8], k[3]);
    i_pmcl_host.stop();
    ok = &k;
    repeat (10) @(negedge mclk);
  endtask
  task automatic rd(input logic [7:0] c, output logic [15:0] d);
    logic k;
    i_pmcl_host.start();
    i_pmcl_host.wbyte({DEV, 1'b0}, k);
    i_pmcl_host.wbyte(c, k);
    // answer crosses both domains first
    repeat (60) @(negedge mclk);
    i_pmcl_host.start();
    i_pmcl_host.wbyte({DEV, 1'b1}, k);
    i_pmcl_host.rbyte(1'b0, d[7:0]);
    i_pmcl_host.rbyte(1'b1, d[15:8]);
    i_pmcl_host.stop();
  endtask
  task automatic t_boot();
    logic ok;
    logic [15:0] d;
    wr(DEV, CMD_VOUT_CMD, 16'h0001, ok);
    `CHK(ok, 1'b0)
    bias_comm_ok = 1'b1;
    repeat (40) @(negedge mclk);
    wr(7'h40, CMD_VOUT_CMD, 16'h0001, ok);
    `CHK(ok, 1'b0)
    rd(CMD_STATUS, d);
    `CHK(d, 16'h0008)
    rd(CMD_BASE_ADDR, d);
    `CHK(d[6:0], 7'h40)
    `CHK(vout_setpoint, 16'h0000)
    `CHK(cfg_crc_fail, 1'b0)
    `CHK(sda_out, 1'b0)
  endtask
  task automatic t_vout();
    logic ok;
    logic [15:0] d;
    wr(DEV, CMD_VOUT_CMD, 16'h1000, ok);
    `CHK(ok, 1'b1)
    for (int m = 0; m < 5; m++) begin
      wr(DEV, CMD_VOUT_MODE, 16'(m), ok);
      `CHK(vout_setpoint, 16'h0640 << m)
    end
    wr(DEV, CMD_VOUT_MODE, 16'h0005, ok);
    rd(CMD_VOUT_MODE, d);
    `CHK(d, 16'h0004)
    `CHK(vout_setpoint, 16'h6400)
  endtask
  task automatic t_apd();
    logic ok;
    wr(DEV, CMD_ANALOG_PD, 16'hf240, ok);
    `CHK(analog_pd_ctl, 16'hf240)
  endtask
  task automatic t_prot();
    logic ok;
    logic [15:0] d;
    wr(DEV, CMD_PROT, 16'h0001, ok);
    wr(DEV, CMD_VOUT_CMD, 16'h0800, ok);
    `CHK(vout_setpoint, 16'h6400)
    rd(CMD_STATUS, d);
    `CHK(d, 16'h0018)
    wr(DEV, CMD_PROT, 16'h0002, ok);
    rd(CMD_VOUT_CMD, d);
    `CHK(d, 16'hffff)
    wr(DEV, CMD_PROT, 16'h0000, ok);
    wr(DEV, CMD_PASSWORD, 16'h5a5a, ok);
    wr(DEV, CMD_PROT, 16'h0008, ok);
    rd(CMD_VOUT_CMD, d);
    `CHK(d, 16'hffff)
    wr(DEV, CMD_PASSWORD, 16'h5a5a, ok);
    rd(CMD_VOUT_CMD, d);
    `CHK(d, 16'h1000)
    wr(DEV, CMD_STATUS, 16'h0010, ok);
    rd(CMD_STATUS, d);
    `CHK(d, 16'h0008)
  endtask
  task automatic t_tlm();
    logic ok;
    logic [15:0] d;
    logic [7:0] c [7] = '{CMD_READ_VIN, CMD_READ_IIN, CMD_READ_VOUT, CMD_READ_IOUT,
                          CMD_READ_TEMP, CMD_READ_POUT, CMD_READ_PIN};
    logic [15:0] e [7] = '{16'h0a01, 16'h0a03, 16'h0a02, 16'h0a04,
                           16'h0a07, 16'h0a06, 16'h0a05};
    wr(DEV, CMD_PROT, 16'h0004, ok);
    for (int i = 0; i < 7; i++) begin
      rd(c[i], d);
      `CHK(d, e[i])
    end
    rd(CMD_VOUT_CMD, d);
    `CHK(d, 16'hffff)
    wr(DEV, CMD_VOUT_CMD, 16'h0800, ok);
    `CHK(vout_setpoint, 16'h6400)
  endtask
  task automatic run_wait();
    for (int i = 0; i < 20 && conv_running !== 1'b1; i++) begin
      @(negedge mclk);
    end
  endtask
  task automatic t_run();
    int n;
    bias_uvlo_ok = 1'b1;
    en_start_ok = 1'b1;
    repeat (10) @(negedge mclk);
    `CHK(conv_running, 1'b0)
    // clock enable low freezes the start path
    ce = 1'b0;
    en_pin = 1'b1;
    repeat (10) @(negedge mclk);
    `CHK(conv_running, 1'b0)
    ce = 1'b1;
    run_wait();
    `CHK({conv_running, hs_drive, ls_drive}, 3'b100)
    ss_above_fb = 1'b1;
    repeat (6) @(negedge mclk);
    `CHK(ls_drive, 1'b1)
    vout_below_floor = 1'b1;
    n = 0;
    repeat (20) begin
      @(negedge mclk);
      n += int'(hs_drive === 1'b1 && ls_drive === 1'b0);
    end
    `CHK(n, 6)
    bias_uvlo_ok = 1'b0;
    repeat (10) @(negedge mclk);
    bias_uvlo_ok = 1'b1;
    repeat (10) @(negedge mclk);
    `CHK(conv_running, 1'b0)
    en_pin = 1'b0;
    repeat (5) @(negedge mclk);
    en_pin = 1'b1;
    run_wait();
    `CHK(conv_running, 1'b1)
  endtask
  initial begin
    // longer than two cycles so the link side sees reset
    repeat (6) @(negedge mclk);
    rst_n = 1'b1;
    repeat (30) @(negedge mclk);
    t_boot();
    t_vout();
    t_apd();
    t_prot();
    t_tlm();
    t_run();
    wrap_up();
  end
endmodule // pmcl_top_tb
